//--- verilog/lst_lockup_supervisor_timer.v
/*
 Windowed lockup supervisor timer: 12-bit down counter behind a 3-bit
 prescaler, window check on reload, debug halt, write protection,
 sticky event status with mask and one interrupt line.
 Assumes a plain register port on mclk; dbgHalt comes from another
 domain and is synchronised here.
*/
`timescale 1ns/1ps
`include "lst_map.vh"

module lst_lockup_supervisor_timer #(
  parameter CNT_W = 12,
  parameter PRE_W = 3
) (
  input wire mclk,
  input wire reset_n,
  input wire [3:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [31:0] regRdata,
  input wire dbgHalt,
  output reg sysReset,
  output reg irq
);

////////////////////////////////////////////////////////////////////////
// Registers

reg [CNT_W-1:0] reloadReg;
reg [CNT_W-1:0] deltaReg;
reg [PRE_W-1:0] preSelReg;
reg enableReg;
reg dbgHaltEnReg;
reg protReg;
reg [CNT_W-1:0] countReg;
reg underflowPendReg;
reg [`LST_EV_W-1:0] statReg;
reg [`LST_EV_W-1:0] maskReg;
reg [2:0] dbgSyncReg;
reg [7:0] pulseReg;
reg [`LST_EV_W-1:0] evNext;
reg [31:0] rdNext;

wire tick;
wire dbgStable;
wire halted;
wire reloadReq;
wire reloadOk;
wire reloadEarly;
wire underflow;
wire cfgWrite;
wire blocked;
wire modeWrite;

////////////////////////////////////////////////////////////////////////
// Debug halt input, three-stage synchroniser

always @(posedge mclk or negedge reset_n) begin
  if (!reset_n) begin
    dbgSyncReg <= 3'h0;
  end else begin
    dbgSyncReg <= {dbgSyncReg[1:0], dbgHalt};
  end
end

// Stage two and three agree before the level counts
reg dbgLevelReg;
always @(posedge mclk or negedge reset_n) begin
  if (!reset_n) begin
    dbgLevelReg <= 1'b0;
  end else if (dbgSyncReg[1] == dbgSyncReg[2]) begin
    dbgLevelReg <= dbgSyncReg[2];
  end
end
assign dbgStable = dbgLevelReg;

assign halted = dbgHaltEnReg & dbgStable;

////////////////////////////////////////////////////////////////////////
// Reload window and write decode

assign reloadReq = regWrite && (regAddr == `LST_ADDR_CTRL) &&
  (regWdata[`LST_CTRL_KEY_HI:`LST_CTRL_KEY_LO] == `LST_KEY_RELOAD) && enableReg;
assign reloadEarly = reloadReq && (countReg > deltaReg);
assign reloadOk = reloadReq && !reloadEarly;

assign cfgWrite = regWrite && ((regAddr == `LST_ADDR_MODE) || (regAddr == `LST_ADDR_DELTA));
assign modeWrite = regWrite && (regAddr == `LST_ADDR_MODE) && !protReg;
assign blocked = cfgWrite && protReg;

// underflowPendReg already set by a tick at zero, and a further tick arrives
assign underflow = enableReg && !halted && tick && !reloadOk && underflowPendReg;

lst_prescaler #(
  .SEL_W(PRE_W),
  .DIV_W(8)
) uPre (
  .mclk(mclk),
  .reset_n(reset_n),
  .run(enableReg & ~halted),
  .restart(reloadOk | ~enableReg),
  .sel(preSelReg),
  .tick(tick)
);

////////////////////////////////////////////////////////////////////////
// Configuration registers

always @(posedge mclk or negedge reset_n) begin
  if (!reset_n) begin
    reloadReg <= `LST_MODE_RLD_RST;
    preSelReg <= `LST_MODE_PRE_RST;
    enableReg <= 1'b0;
    dbgHaltEnReg <= 1'b0;
    deltaReg <= `LST_DELTA_RST;
    protReg <= 1'b0;
  end else if (regWrite) begin
    if (regAddr == `LST_ADDR_MODE && !protReg) begin
      reloadReg <= regWdata[`LST_MODE_RLD_HI:`LST_MODE_RLD_LO];
      preSelReg <= regWdata[`LST_MODE_PRE_HI:`LST_MODE_PRE_LO];
      enableReg <= regWdata[`LST_MODE_EN];
      dbgHaltEnReg <= regWdata[`LST_MODE_DBGHALT];
    end
    if (regAddr == `LST_ADDR_DELTA && !protReg) begin
      deltaReg <= regWdata[CNT_W-1:0];
    end
    if (regAddr == `LST_ADDR_PROT) begin
      if (regWdata[`LST_PROT_KEY_HI:`LST_PROT_KEY_LO] == `LST_KEY_LOCK) begin
        protReg <= 1'b1;
      end else if (regWdata[`LST_PROT_KEY_HI:`LST_PROT_KEY_LO] == `LST_KEY_UNLOCK) begin
        protReg <= 1'b0;
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Down counter

always @(posedge mclk or negedge reset_n) begin
  if (!reset_n) begin
    countReg <= `LST_MODE_RLD_RST;
    underflowPendReg <= 1'b0;
  end else if (!enableReg) begin
    // Take a reload value written with the enable, else counting starts stale
    countReg <= modeWrite ? regWdata[`LST_MODE_RLD_HI:`LST_MODE_RLD_LO] : reloadReg;
    underflowPendReg <= 1'b0;
  end else if (reloadOk) begin
    countReg <= reloadReg;
    underflowPendReg <= 1'b0;
  end else if (underflow) begin
    countReg <= reloadReg;
    underflowPendReg <= 1'b0;
  end else if (tick && !halted) begin
    if (countReg == {CNT_W{1'b0}}) begin
      underflowPendReg <= 1'b1;
    end else begin
      countReg <= countReg - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end
end

////////////////////////////////////////////////////////////////////////
// System reset pulse

always @(posedge mclk or negedge reset_n) begin
  if (!reset_n) begin
    pulseReg <= 8'h00;
    sysReset <= 1'b0;
  end else if (underflow || reloadEarly) begin
    pulseReg <= `LST_RSTPULSE_CYC;
    sysReset <= 1'b1;
  end else if (pulseReg != 8'h00) begin
    pulseReg <= pulseReg - 8'h01;
    sysReset <= (pulseReg != 8'h01);
  end else begin
    sysReset <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////
// Events, status, interrupt

always @* begin
  evNext = {`LST_EV_W{1'b0}};
  evNext[`LST_EV_UNDER] = underflow;
  evNext[`LST_EV_EARLY] = reloadEarly;
  evNext[`LST_EV_BLOCKED] = blocked;
end

always @(posedge mclk or negedge reset_n) begin
  if (!reset_n) begin
    statReg <= {`LST_EV_W{1'b0}};
    maskReg <= {`LST_EV_W{1'b0}};
    irq <= 1'b0;
  end else begin
    // New events win over clear on read
    if (regRead && regAddr == `LST_ADDR_STAT) begin
      statReg <= evNext;
    end else begin
      statReg <= statReg | evNext;
    end
    if (regWrite && regAddr == `LST_ADDR_MASK) begin
      maskReg <= regWdata[`LST_EV_W-1:0];
    end
    irq <= |(((regRead && regAddr == `LST_ADDR_STAT) ? evNext : (statReg | evNext)) & maskReg);
  end
end

////////////////////////////////////////////////////////////////////////
// Read port

always @* begin
  rdNext = 32'h00000000;
  case (regAddr)
    `LST_ADDR_MODE: begin
      rdNext[`LST_MODE_RLD_HI:`LST_MODE_RLD_LO] = reloadReg;
      rdNext[`LST_MODE_PRE_HI:`LST_MODE_PRE_LO] = preSelReg;
      rdNext[`LST_MODE_EN] = enableReg;
      rdNext[`LST_MODE_DBGHALT] = dbgHaltEnReg;
    end
    `LST_ADDR_DELTA: rdNext[CNT_W-1:0] = deltaReg;
    `LST_ADDR_STAT: rdNext[`LST_EV_W-1:0] = statReg;
    `LST_ADDR_MASK: rdNext[`LST_EV_W-1:0] = maskReg;
    `LST_ADDR_COUNT: rdNext[CNT_W-1:0] = countReg;
    `LST_ADDR_PROT: rdNext[0] = protReg;
    default: rdNext = 32'h00000000;
  endcase
end

always @(posedge mclk or negedge reset_n) begin
  if (!reset_n) begin
    regRdata <= 32'h00000000;
  end else if (regRead) begin
    regRdata <= rdNext;
  end else begin
    regRdata <= 32'h00000000;
  end
end

endmodule

//--- verilog/lst_map.vh
/*
 Register offsets, field positions, reset values and timing figures
 for the lockup supervisor timer. Included by its bare name.
*/
`ifndef LST_MAP_VH
`define LST_MAP_VH

// Register word offsets
`define LST_ADDR_CTRL 4'h0
`define LST_ADDR_MODE 4'h1
`define LST_ADDR_DELTA 4'h2
`define LST_ADDR_STAT 4'h3
`define LST_ADDR_MASK 4'h4
`define LST_ADDR_COUNT 4'h5
`define LST_ADDR_PROT 4'h6

// CTRL: reload strobe with key
`define LST_KEY_RELOAD 16'h5a3c
`define LST_CTRL_KEY_HI 31
`define LST_CTRL_KEY_LO 16

// MODE fields
`define LST_MODE_RLD_HI 11
`define LST_MODE_RLD_LO 0
`define LST_MODE_PRE_HI 14
`define LST_MODE_PRE_LO 12
`define LST_MODE_EN 16
`define LST_MODE_DBGHALT 17
`define LST_MODE_RLD_RST 12'hfff
`define LST_MODE_PRE_RST 3'h0

// DELTA field
`define LST_DELTA_RST 12'hfff

// PROT: key words and state bit
`define LST_KEY_LOCK 16'h00a5
`define LST_KEY_UNLOCK 16'h35ca
`define LST_PROT_KEY_HI 15
`define LST_PROT_KEY_LO 0

// STAT/MASK bits
`define LST_EV_UNDER 0
`define LST_EV_EARLY 1
`define LST_EV_BLOCKED 2
`define LST_EV_W 3

// Reset pulse length in ns, and the same in 50 ns clock cycles
`define LST_CLK_NS 50
`define LST_RSTPULSE_NS 1000
// Sized to the pulse counter so no bits are dropped on load
`define LST_RSTPULSE_CYC 8'h14

`endif

//--- verilog/lst_prescaler.v
/*
 Prescaler for the lockup supervisor timer: a divider, held while run is low, that gives
 one-cycle tick pulses at mclk / 2^(sel+1).
 Assumes sel is steady between restarts; a restart clears the divider.
*/
`timescale 1ns/1ps

module lst_prescaler #(
  parameter SEL_W = 3,
  parameter DIV_W = 8
) (
  input wire mclk,
  input wire reset_n,
  input wire run,
  input wire restart,
  input wire [SEL_W-1:0] sel,
  output reg tick
);

reg [DIV_W-1:0] divReg;
wire [DIV_W-1:0] divNext;
wire [DIV_W-1:0] limit;

assign divNext = divReg + {{(DIV_W-1){1'b0}}, 1'b1};
// Divide by 2, 4 ... 256 for selections 0 to 7
assign limit = (({{(DIV_W-1){1'b0}}, 1'b1} << sel) << 1) - {{(DIV_W-1){1'b0}}, 1'b1};

always @(posedge mclk or negedge reset_n) begin
  if (!reset_n) begin
    divReg <= {DIV_W{1'b0}};
    tick <= 1'b0;
  end else if (restart) begin
    divReg <= {DIV_W{1'b0}};
    tick <= 1'b0;
  end else if (run) begin
    tick <= (divReg == limit);
    divReg <= (divReg == limit) ? {DIV_W{1'b0}} : divNext;
  end else begin
    tick <= 1'b0;
  end
end

endmodule

//--- testbench/lst_properties.sv
/* Checker for the lockup supervisor timer, bound to its top module.
 Assumes the register map header and writes taken on the strobe edge. */
`timescale 1ns/1ps
`include "lst_map.vh"
module lst_checker (
  input wire mclk,
  input wire reset_n,
  input wire [3:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWrite,
  input wire regRead,
  input wire [31:0] regRdata,
  input wire dbgHalt,
  input wire sysReset,
  input wire irq
);
  reg locked_reg, en_reg, haltEn_reg;
  reg [2:0] mask_reg, quiet_reg;
  reg [4:0] pulse_reg;
  wire isWr = regWrite && regAddr == `LST_ADDR_PROT;
  // Reload strobes can legally fire a reset, so they break the quiet run
  wire quiet = (!en_reg || (dbgHalt && haltEn_reg)) && !(regWrite && regAddr == `LST_ADDR_CTRL);
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      locked_reg <= 1'b0;
      en_reg <= 1'b0;
      haltEn_reg <= 1'b0;
      mask_reg <= 3'h0;
      quiet_reg <= 3'h0;
      pulse_reg <= 5'h0;
    end else begin
      if (isWr && regWdata[15:0] == `LST_KEY_LOCK)
        locked_reg <= 1'b1;
      if (isWr && regWdata[15:0] == `LST_KEY_UNLOCK)
        locked_reg <= 1'b0;
      if (regWrite && regAddr == `LST_ADDR_MODE && !locked_reg) begin
        en_reg <= regWdata[16];
        haltEn_reg <= regWdata[17];
      end
      if (regWrite && regAddr == `LST_ADDR_MASK)
        mask_reg <= regWdata[2:0];
      pulse_reg <= sysReset ? pulse_reg + 5'h1 : 5'h0;
      quiet_reg <= !quiet ? 3'h0 : (quiet_reg == 3'h7 ? quiet_reg : quiet_reg + 3'h1);
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence pulseEnd;
    $fell(sysReset);
  endsequence
  pulse_len_a: assert property (pulseEnd |-> pulse_reg == 5'h14)
    else $error("reset pulse length wrong");
  quiet_hold_a: assert property (quiet_reg == 3'h7 |-> !$rose(sysReset))
    else $error("reset while halted or disabled");
  blocked_wr_a: assert property (regWrite && regAddr == `LST_ADDR_MODE && locked_reg
    && mask_reg[2] |-> ##[1:3] irq)
    else $error("blocked write gave no interrupt");
  lock_read_a: assert property (regRead && regAddr == `LST_ADDR_PROT |=>
    regRdata[0] == locked_reg)
    else $error("lock state read wrong");
  rd_idle_a: assert property (!regRead |=> regRdata == 32'h0)
    else $error("read data outside read slot");
  irq_mask_a: assert property (mask_reg == 3'h0 |=> !irq)
    else $error("interrupt with all masked");
endmodule
bind lst_lockup_supervisor_timer lst_checker chk_i (.mclk(mclk), .reset_n(reset_n),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
  .regRdata(regRdata), .dbgHalt(dbgHalt), .sysReset(sysReset), .irq(irq));

//--- testbench/lst_lockup_supervisor_timer_bench.sv
/* Bench for the lockup supervisor timer: registers, window, halt, lock.
 Assumes the register map header and the checker bound alongside. */
`timescale 1ns/1ps
`include "lst_map.vh"
module lst_lockup_supervisor_timer_bench;
  reg mclk = 0, reset_n = 0, regWrite = 0, regRead = 0, dbgHalt = 0, rdPend = 0;
  reg [3:0] regAddr = 4'h0;
  reg [31:0] regWdata = 32'h0, rnd = 32'h6152;
  wire [31:0] regRdata;
  wire sysReset, irq;
  logic [31:0] expQ[$];
  int err_count = 0, checked = 0, n, i;
  lst_lockup_supervisor_timer dut (.mclk(mclk), .reset_n(reset_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .dbgHalt(dbgHalt), .sysReset(sysReset), .irq(irq));
  initial forever #25 mclk = ~mclk;
  ////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  task end_sim;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task wr(input [3:0] a, input [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
    @(posedge mclk);
  endtask
  task rd(input [3:0] a, input [31:0] e);
    regAddr <= a;
    regRead <= 1'b1;
    expQ.push_back(e);
    @(posedge mclk);
    regRead <= 1'b0;
    @(posedge mclk);
  endtask
  // Waits for sysReset to reach lvl; n holds the cycles taken
  task waitLvl(input logic lvl, input int lim);
    n = 0;
    while (sysReset !== lvl && n < lim) begin
      @(posedge mclk);
      n++;
    end
    if (n >= lim) begin
      err_count++;
      end_sim;
    end
  endtask
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  always @(posedge mclk) begin
    if (rdPend) chk("rdata", regRdata, expQ.size() ? expQ.pop_front() : 32'hdead);
    rdPend <= regRead;
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    for (i = 1; i < 8; i++) rd(i[3:0], (i == 1 || i == 2 || i == 5) ? 32'hfff : 32'h0);
    $display("reset values done");
    for (i = 0; i < 4; i++) begin
      rnd = xs(rnd);
      wr(`LST_ADDR_MODE, rnd & 32'h27fff);
      rd(`LST_ADDR_MODE, rnd & 32'h27fff);
      rd(`LST_ADDR_COUNT, rnd & 32'hfff);
    end
    wr(`LST_ADDR_MASK, 32'h7);
    for (i = 0; i < 3; i++) begin
      wr(`LST_ADDR_MODE, 32'h10003 | (i << 12));
      waitLvl(1'b1, 400);
      chk("rate", n, (10 << i) + 1);
      wr(`LST_ADDR_MODE, 32'h3);
      chk("irq", irq, 1);
      rd(`LST_ADDR_STAT, 32'h1);
      waitLvl(1'b0, 40);
    end
    $display("underflow done");
    wr(`LST_ADDR_DELTA, 32'h5);
    wr(`LST_ADDR_MODE, 32'h17fff);
    wr(`LST_ADDR_CTRL, {`LST_KEY_RELOAD, 16'h0});
    waitLvl(1'b1, 10);
    wr(`LST_ADDR_MODE, 32'h7fff);
    rd(`LST_ADDR_STAT, 32'h2);
    waitLvl(1'b0, 40);
    wr(`LST_ADDR_DELTA, 32'hfff);
    wr(`LST_ADDR_MODE, 32'h11040);
    repeat (40) @(posedge mclk);
    wr(`LST_ADDR_CTRL, {`LST_KEY_RELOAD, 16'h0});
    rd(`LST_ADDR_COUNT, 32'h40);
    chk("sysReset", sysReset, 0);
    wr(`LST_ADDR_MODE, 32'h0);
    rd(`LST_ADDR_STAT, 32'h0);
    $display("window done");
    dbgHalt <= 1'b1;
    repeat (6) @(posedge mclk);
    wr(`LST_ADDR_MODE, 32'h30003);
    repeat (60) @(posedge mclk);
    chk("sysReset", sysReset, 0);
    rd(`LST_ADDR_COUNT, 32'h3);
    dbgHalt <= 1'b0;
    waitLvl(1'b1, 60);
    wr(`LST_ADDR_MODE, 32'h3);
    rd(`LST_ADDR_STAT, 32'h1);
    waitLvl(1'b0, 40);
    $display("debug halt done");
    wr(`LST_ADDR_MODE, 32'h123);
    wr(`LST_ADDR_PROT, `LST_KEY_LOCK);
    rd(`LST_ADDR_PROT, 32'h1);
    wr(`LST_ADDR_MODE, 32'h456);
    wr(`LST_ADDR_DELTA, 32'h0);
    rd(`LST_ADDR_MODE, 32'h123);
    rd(`LST_ADDR_DELTA, 32'hfff);
    rd(`LST_ADDR_STAT, 32'h4);
    wr(`LST_ADDR_PROT, `LST_KEY_UNLOCK);
    wr(`LST_ADDR_MODE, 32'h456);
    rd(`LST_ADDR_MODE, 32'h456);
    rd(`LST_ADDR_PROT, 32'h0);
    $display("protection done");
    end_sim;
  end
endmodule
